// File: rtl/power_osc_map.svh
`ifndef POWER_OSC_MAP_SVH
`define POWER_OSC_MAP_SVH
// Function
// - set select takes slow clock from pin
// - bit 0 enables automatic slow oscillator calibration
// - trim word 7:4, feedback word split
// - bit 5 switches internal regulator off
// - switching clock divide-by-4 or rate multiplier
// - multiplier value from two registers, 15 bits
// - bit 6 enables battery detector
// - bits 5:4 pick detector threshold
// - level mode fixes receive level 1.4 V
// - bits 6:4 set level, 000b unused
// - bit 0 selects sleep with retention

// register indices, byte address is four times the index
`define IDX_SLOW_OSC_SELECT_CFG     10'h06d
`define IDX_RC_OSC_TRIM_HIGH        10'h06e
`define IDX_RC_OSC_TRIM_LOW         10'h06f
`define IDX_REGULATOR_DISABLE_CFG   10'h075
`define IDX_REGULATOR_CLOCK_HIGH    10'h076
`define IDX_REGULATOR_CLOCK_LOW     10'h077
`define IDX_BATTERY_REG_MODE_CFG    10'h078
`define IDX_REG_LEVEL_SLEEP_CFG     10'h079

// reset values
`define RST_SLOW_OSC_SELECT_CFG     8'h30
`define RST_RC_OSC_TRIM_HIGH        8'h70
`define RST_RC_OSC_TRIM_LOW         8'h00
`define RST_REGULATOR_DISABLE_CFG   8'h17
`define RST_REGULATOR_CLOCK_HIGH    8'h20
`define RST_REGULATOR_CLOCK_LOW     8'h00
`define RST_BATTERY_REG_MODE_CFG    8'h39
`define RST_REG_LEVEL_SLEEP_CFG     8'h42

// writable bits; the rest hold their reset value
`define WM_SLOW_OSC_SELECT_CFG      8'h03
`define WM_RC_OSC_TRIM_HIGH         8'hff
`define WM_RC_OSC_TRIM_LOW          8'h80
`define WM_REGULATOR_DISABLE_CFG    8'h20
`define WM_REGULATOR_CLOCK_HIGH     8'hff
`define WM_REGULATOR_CLOCK_LOW      8'hff
`define WM_BATTERY_REG_MODE_CFG     8'h7c
`define WM_REG_LEVEL_SLEEP_CFG      8'h71

// field positions
`define EXT_SLOW_BIT     1
`define AUTO_TRIM_BIT    0
`define TRIM_MSB         7
`define TRIM_LSB         4
`define FB_HIGH_MSB      3
`define FB_LOW_BIT       7
`define REG_OFF_BIT      5
`define RM_EN_BIT        7
`define RM_HIGH_MSB      6
`define DET_EN_BIT       6
`define TH_MSB           5
`define TH_LSB           4
`define LVL_MODE_BIT     3
`define LIN_BYP_BIT      2
`define LVL_MSB          6
`define LVL_LSB          4
`define SLEEP_BIT        0

// fixed receive level code (1.4 V) and switching clock figures
`define RX_FIXED_LEVEL   3'h3
`define LEVEL_UNUSED     3'h0
`define FIXED_DIV_RATIO  4
`define RM_WIDTH         15
`define ADDR_WIDTH       12
`endif

// File: rtl/power_osc_pkg.sv
package power_osc_pkg;
    // battery detector threshold codes, voltage falling as code rises
    typedef enum logic [1:0] {
        th_2v7,
        th_2v5,
        th_2v3,
        th_2v1
    } battery_threshold_e;

    // static control words toward analog blocks
    typedef struct packed {
        logic               external_slow_clock_sel;
        logic               auto_slow_osc_trim_en;
        logic [3:0]         slow_osc_trim_word;
        logic [4:0]         slow_osc_feedback_word;
        logic               internal_regulator_off;
        logic               rate_multiplier_en;
        logic [14:0]        rate_multiplier_value;
        logic               battery_detector_en;
        battery_threshold_e battery_threshold_sel;
        logic               regulator_level_mode;
        logic               linear_reg_bypass;
        logic [2:0]         regulator_output_level;
        logic [2:0]         regulator_level_now;
        logic               level_code_unused;
        logic               sleep_retain_buffers;
    } power_ctrl_s;

    typedef logic [7:0] reg_byte_t;
endpackage

// File: rtl/power_osc_config_regs.sv
// Implementation choice: the APB slave port.
`include "power_osc_map.svh"

module power_osc_config_regs #(
    parameter int FIXED_DIV = `FIXED_DIV_RATIO,
    parameter int RM_W      = `RM_WIDTH
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`ADDR_WIDTH-1:0]      paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // slow clock sources and radio state
    input  wire logic                        internal_slow_osc_clk,
    input  wire logic                        gpio_slow_clk,
    input  wire logic                        tx_active,
    // control outputs
    output power_osc_pkg::power_ctrl_s       ctrl,
    output logic                             slow_clk,
    output logic                             switch_tick
);
    import power_osc_pkg::*;

    //------------------------------------------------------------
    // register table
    //------------------------------------------------------------
    localparam int NREG = 8;

    // word indices
    localparam logic [9:0] IDX [NREG] = '{
        `IDX_SLOW_OSC_SELECT_CFG,
        `IDX_RC_OSC_TRIM_HIGH,
        `IDX_RC_OSC_TRIM_LOW,
        `IDX_REGULATOR_DISABLE_CFG,
        `IDX_REGULATOR_CLOCK_HIGH,
        `IDX_REGULATOR_CLOCK_LOW,
        `IDX_BATTERY_REG_MODE_CFG,
        `IDX_REG_LEVEL_SLEEP_CFG
    };

    // reset values
    localparam reg_byte_t RST [NREG] = '{
        `RST_SLOW_OSC_SELECT_CFG,
        `RST_RC_OSC_TRIM_HIGH,
        `RST_RC_OSC_TRIM_LOW,
        `RST_REGULATOR_DISABLE_CFG,
        `RST_REGULATOR_CLOCK_HIGH,
        `RST_REGULATOR_CLOCK_LOW,
        `RST_BATTERY_REG_MODE_CFG,
        `RST_REG_LEVEL_SLEEP_CFG
    };

    // writable bit masks
    localparam reg_byte_t WM [NREG] = '{
        `WM_SLOW_OSC_SELECT_CFG,
        `WM_RC_OSC_TRIM_HIGH,
        `WM_RC_OSC_TRIM_LOW,
        `WM_REGULATOR_DISABLE_CFG,
        `WM_REGULATOR_CLOCK_HIGH,
        `WM_REGULATOR_CLOCK_LOW,
        `WM_BATTERY_REG_MODE_CFG,
        `WM_REG_LEVEL_SLEEP_CFG
    };

    // entry positions in the table
    localparam int E_SLOW  = 0;
    localparam int E_TRH   = 1;
    localparam int E_TRL   = 2;
    localparam int E_RDIS  = 3;
    localparam int E_CKH   = 4;
    localparam int E_CKL   = 5;
    localparam int E_MODE  = 6;
    localparam int E_LVL   = 7;

    //------------------------------------------------------------
    // address decode
    //------------------------------------------------------------
    logic [NREG-1:0] hit;          // one-hot entry match
    logic            word_ok;      // aligned access
    logic            mapped;       // some entry matched
    reg_byte_t       rd_byte;      // selected read byte
    reg_byte_t       reg_q [NREG]; // register contents
    reg_byte_t       reg_d [NREG]; // next contents
    logic            pready_q;     // access phase ready

    // per-entry match on word index
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_dec
            assign hit[g] = word_ok && (paddr[`ADDR_WIDTH-1:2] == IDX[g]);
        end
    endgenerate

    assign word_ok = (paddr[1:0] == 2'h0);
    assign mapped  = |hit;

    // read mux, reserved bits show reset value
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_byte = reg_q[i];
            end
        end
    end

    //------------------------------------------------------------
    // register storage
    //------------------------------------------------------------
    logic      wr_go;              // write completes this edge

    // write takes effect at the completing access edge
    assign wr_go = psel && penable && pready_q && pwrite && pstrb[0];

    // merge writable bits, keep reserved at reset value
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            reg_d[i] = reg_q[i];
            if (wr_go && hit[i]) begin
                reg_d[i] = (pwdata[7:0] & WM[i]) | (RST[i] & ~WM[i]);
            end
        end
    end

    // register bank flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= RST;
        end else begin
            reg_q <= reg_d;
        end
    end

    //------------------------------------------------------------
    // apb answer
    //------------------------------------------------------------
    logic        pready_d;         // ready for next cycle
    logic        pslverr_q;        // unmapped access
    logic        pslverr_d;
    logic [31:0] prdata_q;         // read data
    logic [31:0] prdata_d;

    // answer prepared in setup, shown in access
    always_comb begin
        pready_d  = psel && !penable;
        pslverr_d = pslverr_q;
        prdata_d  = prdata_q;
        if (psel && !penable) begin
            // setup phase: latch answer
            pslverr_d = !mapped;
            prdata_d  = (!pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else if (!psel) begin
            // idle: clear error
            pslverr_d = 1'b0;
        end
    end

    // answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    //------------------------------------------------------------
    // control word decode
    //------------------------------------------------------------
    power_ctrl_s ctrl_q;           // registered control word
    power_ctrl_s ctrl_d;

    // fields out of the register bytes
    always_comb begin
        ctrl_d = ctrl_q;
        ctrl_d.external_slow_clock_sel = reg_q[E_SLOW][`EXT_SLOW_BIT];
        ctrl_d.auto_slow_osc_trim_en   = reg_q[E_SLOW][`AUTO_TRIM_BIT];
        ctrl_d.slow_osc_trim_word      = reg_q[E_TRH][`TRIM_MSB:`TRIM_LSB];
        ctrl_d.slow_osc_feedback_word  = {reg_q[E_TRH][`FB_HIGH_MSB:0],
                                          reg_q[E_TRL][`FB_LOW_BIT]};
        ctrl_d.internal_regulator_off  = reg_q[E_RDIS][`REG_OFF_BIT];
        ctrl_d.rate_multiplier_en      = reg_q[E_CKH][`RM_EN_BIT];
        ctrl_d.rate_multiplier_value   = {reg_q[E_CKH][`RM_HIGH_MSB:0],
                                          reg_q[E_CKL]};
        ctrl_d.battery_detector_en     = reg_q[E_MODE][`DET_EN_BIT];
        ctrl_d.battery_threshold_sel   =
            battery_threshold_e'(reg_q[E_MODE][`TH_MSB:`TH_LSB]);
        ctrl_d.regulator_level_mode    = reg_q[E_MODE][`LVL_MODE_BIT];
        ctrl_d.linear_reg_bypass       = reg_q[E_MODE][`LIN_BYP_BIT];
        ctrl_d.regulator_output_level  = reg_q[E_LVL][`LVL_MSB:`LVL_LSB];
        ctrl_d.level_code_unused       =
            (reg_q[E_LVL][`LVL_MSB:`LVL_LSB] == `LEVEL_UNUSED);
        // receive uses fixed level in mode 1
        if (reg_q[E_MODE][`LVL_MODE_BIT] && !tx_active) begin
            ctrl_d.regulator_level_now = `RX_FIXED_LEVEL;
        end else begin
            ctrl_d.regulator_level_now = reg_q[E_LVL][`LVL_MSB:`LVL_LSB];
        end
        ctrl_d.sleep_retain_buffers    = reg_q[E_LVL][`SLEEP_BIT];
    end

    // control word flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl = ctrl_q;

    //------------------------------------------------------------
    // slow clock source
    //------------------------------------------------------------
    logic slow_clk_q;              // selected slow clock
    logic slow_clk_d;

    // pin source or internal oscillator
    always_comb begin
        if (ctrl_q.external_slow_clock_sel) begin
            slow_clk_d = gpio_slow_clk;
        end else begin
            slow_clk_d = internal_slow_osc_clk;
        end
    end

    // slow clock flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_clk_q <= 1'b0;
        end else begin
            slow_clk_q <= slow_clk_d;
        end
    end

    assign slow_clk = slow_clk_q;

    //------------------------------------------------------------
    // regulator switching tick
    //------------------------------------------------------------
    localparam int DW = (FIXED_DIV > 1) ? $clog2(FIXED_DIV) : 1;

    logic [DW-1:0]   div_q;        // fixed divider count
    logic [DW-1:0]   div_d;
    logic [RM_W-1:0] acc_q;        // rate multiplier phase
    logic [RM_W-1:0] acc_d;
    logic            tick_q;       // one-cycle switching pulse
    logic            tick_d;
    logic [RM_W:0]   acc_sum;      // phase plus step, with carry

    // divide-by-fixed or phase accumulator overflow
    always_comb begin
        acc_sum = {1'b0, acc_q} + {1'b0, ctrl_q.rate_multiplier_value[RM_W-1:0]};
        div_d   = div_q;
        acc_d   = acc_q;
        tick_d  = 1'b0;
        if (ctrl_q.internal_regulator_off) begin
            // external supply: no switching
            div_d = '0;
            acc_d = '0;
        end else if (ctrl_q.rate_multiplier_en) begin
            // pulse rate is value / 2^15 of pclk
            acc_d  = acc_sum[RM_W-1:0];
            tick_d = acc_sum[RM_W];
            div_d  = '0;
        end else begin
            // pulse every fixed divide count
            acc_d = '0;
            if (div_q == DW'(FIXED_DIV - 1)) begin
                div_d  = '0;
                tick_d = 1'b1;
            end else begin
                div_d = div_q + DW'(1);
            end
        end
    end

    // switching tick flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= '0;
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign switch_tick = tick_q;
endmodule

// File: tb/power_osc_monitor.sv
`include "power_osc_map.svh"
// ------------------------------------------
// checker on the config block ports
// ------------------------------------------
module power_osc_monitor #(
    parameter int FIXED_DIV = 4,
    parameter int RM_W      = 15
) (
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // apb slave side
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // slow clocks and radio state
    input wire logic                   internal_slow_osc_clk,
    input wire logic                   gpio_slow_clk,
    input wire logic                   tx_active,
    // control outputs
    input wire power_osc_pkg::power_ctrl_s ctrl,
    input wire logic                   slow_clk,
    input wire logic                   switch_tick
);
    import power_osc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic sel = ctrl.external_slow_clock_sel;  // pin clock chosen
    wire logic off = ctrl.internal_regulator_off;   // regulator off
    wire logic wacc = psel && penable && pwrite;    // write access phase
    // divide-by-4 mode with regulator running
    wire logic div_mode = !ctrl.rate_multiplier_en && !off;
    // tick after five cycles in divide mode
    sequence div_on;
        div_mode [*5] ##0 switch_tick;
    endsequence
    // three quiet cycles, then the next tick
    sequence div_gap;
        !switch_tick [*3] ##1 switch_tick;
    endsequence
    chk_ext_clk: assert property (
        $past(presetn) && sel && $past(sel) && $past(sel, 2)
        |-> slow_clk == $past(gpio_slow_clk))
        else $error("slow clock does not follow pin");
    chk_int_clk: assert property (
        $past(presetn) && !sel && !$past(sel) && !$past(sel, 2)
        |-> slow_clk == $past(internal_slow_osc_clk))
        else $error("slow clock does not follow internal oscillator");
    chk_rx_fixed: assert property (
        ctrl.regulator_level_mode && !$past(tx_active) |-> ctrl.regulator_level_now == 3'h3)
        else $error("receive level not fixed");
    chk_level_prog: assert property (
        !(ctrl.regulator_level_mode && !$past(tx_active))
        |-> ctrl.regulator_level_now == ctrl.regulator_output_level)
        else $error("programmed level not applied");
    chk_unused_code: assert property (
        $past(presetn) |-> ctrl.level_code_unused == (ctrl.regulator_output_level == 3'h0))
        else $error("unused level code flag wrong");
    chk_tick_div4: assert property (
        div_on |=> div_gap or (##[0:3] !div_mode))
        else $error("switch tick not every four cycles");
    chk_tick_off: assert property (
        off && $past(off) |-> !switch_tick)
        else $error("switch tick while regulator off");
    chk_mult_hold: assert property (
        presetn && !wacc |-> ##2 $stable(ctrl.rate_multiplier_value))
        else $error("multiplier changed without write");
endmodule

// File: tb/apb_host_model.sv
`include "power_osc_map.svh"
// ------------------------------------------
// host controller driving apb
// ------------------------------------------
module apb_host_model (
    // clock
    input  wire logic                   pclk,
    // request
    output logic                        psel,
    output logic                        penable,
    output logic                        pwrite,
    output logic [`ADDR_WIDTH-1:0]      paddr,
    output logic [31:0]                 pwdata,
    output logic [3:0]                  pstrb,
    // answer
    input  wire logic [31:0]            prdata,
    input  wire logic                   pready,
    input  wire logic                   pslverr,
    // wait limit ran out
    output logic                        tmo
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, tmo} = '0;
    end
    // one transfer, held until pready sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        if (pready !== 1'b1) tmo = 1'b1;
        // released address and data lines show no stale value; pwrite and pstrb hold
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// File: tb/tb.sv
`include "power_osc_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
// ------------------------------------------
// self-checking bench
// ------------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import power_osc_pkg::*;
    logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, tmo, err;
    logic [`ADDR_WIDTH-1:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, r_in, r_st;
    logic [3:0]  pstrb;
    logic        internal_slow_osc_clk = 0, gpio_slow_clk = 0, tx_active = 0;
    logic        slow_clk, switch_tick;
    power_ctrl_s ctrl;
    int          mismatches = 0, check_count = 0, ticks;
    logic [31:0] sa = 32'h33b2_53d6, sb = 32'h33b2_53d6;  // stimulus seeds
    reg_byte_t   sh [8];                                 // expected contents
    localparam logic [9:0] IDX [8] = '{`IDX_SLOW_OSC_SELECT_CFG, `IDX_RC_OSC_TRIM_HIGH,
        `IDX_RC_OSC_TRIM_LOW, `IDX_REGULATOR_DISABLE_CFG, `IDX_REGULATOR_CLOCK_HIGH,
        `IDX_REGULATOR_CLOCK_LOW, `IDX_BATTERY_REG_MODE_CFG, `IDX_REG_LEVEL_SLEEP_CFG};
    localparam reg_byte_t RST [8] = '{8'h30, 8'h70, 8'h00, 8'h17, 8'h20, 8'h00, 8'h39, 8'h42};
    localparam reg_byte_t WM [8]  = '{8'h03, 8'hff, 8'h80, 8'h20, 8'hff, 8'hff, 8'h7c, 8'h71};
    always #2.5 pclk = ~pclk;
    // xorshift stream
    function automatic logic [31:0] xs(inout logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // value software may write: reserved bits at default, bypass low
    function automatic reg_byte_t legal(int i, reg_byte_t v);
        reg_byte_t w;
        w = (v & WM[i]) | (RST[i] & ~WM[i]);
        if (i == 6) w[2] = 1'b0;
        return w;
    endfunction
    power_osc_config_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .internal_slow_osc_clk(internal_slow_osc_clk),
        .gpio_slow_clk(gpio_slow_clk), .tx_active(tx_active), .ctrl(ctrl),
        .slow_clk(slow_clk), .switch_tick(switch_tick));
    apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tmo(tmo));
    // random slow clocks and radio state
    always @(posedge pclk) begin
        r_in = xs(sa);
        internal_slow_osc_clk <= r_in[0];
        gpio_slow_clk         <= r_in[1];
        tx_active             <= r_in[5];
    end
    // counts and verdict
    task automatic wrap_up();
        if (tmo) mismatches++;
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(int i, reg_byte_t v);
        sh[i] = legal(i, v);
        host.xfer(1'b1, {IDX[i], 2'b00}, {24'h0, sh[i]}, 4'hf, rd_v, err);
        `CHK(err, 1'b0)
        if (tmo) wrap_up();
    endtask
    task automatic rd(int i);
        host.xfer(1'b0, {IDX[i], 2'b00}, 32'h0, 4'hf, rd_v, err);
        `CHK(rd_v, {24'h0, sh[i]})
        if (tmo) wrap_up();
    endtask
    // control word against expected contents
    task automatic chkc();
        repeat (2) @(posedge pclk);
        `CHK(ctrl.external_slow_clock_sel, sh[0][1])
        `CHK(ctrl.auto_slow_osc_trim_en, sh[0][0])
        `CHK(ctrl.slow_osc_trim_word, sh[1][7:4])
        `CHK(ctrl.slow_osc_feedback_word, {sh[1][3:0], sh[2][7]})
        `CHK(ctrl.internal_regulator_off, sh[3][5])
        `CHK(ctrl.rate_multiplier_en, sh[4][7])
        `CHK(ctrl.rate_multiplier_value, {sh[4][6:0], sh[5]})
        `CHK(ctrl.battery_detector_en, sh[6][6])
        `CHK(ctrl.battery_threshold_sel, sh[6][5:4])
        `CHK(ctrl.regulator_level_mode, sh[6][3])
        `CHK(ctrl.regulator_output_level, sh[7][6:4])
        `CHK(ctrl.sleep_retain_buffers, sh[7][0])
    endtask
    // ticks over a fixed window
    task automatic count(int exp);
        ticks = 0;
        repeat (8) @(posedge pclk);
        repeat (4096) begin
            @(posedge pclk);
            ticks += switch_tick;
        end
        `CHK(ticks, exp)
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, then all-zero and all-one corners
        for (int i = 0; i < 8; i++) begin
            sh[i] = RST[i];
            rd(i);
        end
        chkc();
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 8; i++) wr(i, k ? 8'hff : 8'h00);
            for (int i = 0; i < 8; i++) rd(i);
            chkc();
        end
        // random writes with readback
        repeat (40) begin
            r_st = xs(sb);
            wr(int'(r_st[10:8]), r_st[7:0]);
            rd(int'(r_st[10:8]));
            chkc();
        end
        // unmapped, misaligned and byte-0-strobe-off accesses
        host.xfer(1'b0, 12'h1c0, 32'h0, 4'hf, rd_v, err);
        `CHK(err, 1'b1)
        `CHK(rd_v, 32'h0)
        host.xfer(1'b1, {IDX[1], 2'b01}, ~{24'h0, sh[1]}, 4'hf, rd_v, err);
        `CHK(err, 1'b1)
        host.xfer(1'b1, {IDX[1], 2'b00}, ~{24'h0, sh[1]}, 4'he, rd_v, err);
        `CHK(err, 1'b0)
        rd(1);
        // switching clock modes
        wr(3, 8'h00);
        wr(4, 8'h20);
        wr(5, 8'h00);
        count(1024);
        wr(4, 8'h90);
        count(512);
        wr(4, 8'h80);
        wr(5, 8'h80);
        count(16);
        wr(3, 8'h20);
        count(0);
        chkc();
        wrap_up();
    end
endmodule
bind power_osc_config_regs power_osc_monitor #(.FIXED_DIV(FIXED_DIV), .RM_W(RM_W)) mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_slow_osc_clk(internal_slow_osc_clk),
    .gpio_slow_clk(gpio_slow_clk), .tx_active(tx_active), .ctrl(ctrl),
    .slow_clk(slow_clk), .switch_tick(switch_tick));
